// ==== framer_model.sv ====
module framer_model (
   // Clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // Bench control
   input wire logic run,
   input wire logic slow,
   input wire logic injectErr,
   // Line side
   input wire logic txData,
   output logic txBitEn,
   output logic rxBitEn,
   output logic rxData
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [2:0] phase_q;
   logic [2:0] phase_d;
   always_comb begin
      phase_d = phase_q + 3'h1;
   end
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         phase_q <= 3'h0;
      end else begin
         phase_q <= phase_d;
      end
   end
   assign txBitEn = run && (slow ? phase_q == 3'h7 : phase_q[1:0] == 2'h3);
   assign rxBitEn = txBitEn;
   // Loops the sent bit back; between slots the line shows the opposite level.
   assign rxData = rxBitEn ? (txData ^ injectErr) : ~txData;
endmodule

// ==== pattern_detector.sv ====
`include "pattern_gen_detect_defs.svh"

module pattern_detector import pattern_gen_detect_pkg::*; #(
   parameter int WIN_BITS = `SYNC_WINDOW_BITS,
   parameter int ERR_LIMIT = `LOSS_ERR_LIMIT
) (
   // Clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // Configuration
   input wire logic patType,
   input wire logic rxInvert,
   input wire logic autoResync,
   input wire logic manualResync,
   input wire logic [4:0] lenField,
   input wire logic [4:0] tapField,
   // Bit stream
   input wire logic bitEn,
   input wire logic rxData,
   // Results
   output logic syncState,
   output logic syncChange,
   output logic bitError,
   output logic bitSeen,
   output logic [31:0] rxHist
);

   generate
      if (WIN_BITS < 2 || WIN_BITS > 63 || ERR_LIMIT < 1 || ERR_LIMIT > WIN_BITS) begin : g_bad
         $error("WIN_BITS or ERR_LIMIT out of range");
      end
   endgenerate

   localparam logic [5:0] WIN = 6'(WIN_BITS);
   localparam logic [5:0] LIM = 6'(ERR_LIMIT);

   detCore_t s_q, s_d;
   logic b;
   logic pred;
   logic err;
   logic [5:0] errSum;

   always_comb begin
      s_d = s_q;
      s_d.syncChg = 1'b0;
      s_d.bitErr = 1'b0;
      s_d.bitSeen = 1'b0;
      b = rxData ^ rxInvert;
      pred = patType ? s_q.shreg[lenField] : (s_q.shreg[lenField] ^ s_q.shreg[tapField]);
      err = b ^ pred;
      errSum = s_q.winErr + {5'h00, err};
      if (manualResync) begin
         s_d.st = DET_SEARCH;
         s_d.runCnt = 6'h00;
         if (s_q.sync) begin
            s_d.sync = 1'b0;
            s_d.syncChg = 1'b1;
         end
      end else if (bitEn) begin
         s_d.bitSeen = 1'b1;
         s_d.rxHist = {s_q.rxHist[30:0], b};
         s_d.bitErr = err && s_q.sync;
         s_d.runCnt = err ? 6'h00 : ((s_q.runCnt >= WIN) ? WIN : s_q.runCnt + 6'h01);
         if (s_q.st == DET_SEARCH) begin
            // Searching reloads from the line so the detector aligns itself.
            s_d.shreg = {s_q.shreg[30:0], b};
            if (!err && s_q.runCnt == WIN - 6'h01) begin
               s_d.st = DET_SYNC;
               s_d.sync = 1'b1;
               s_d.syncChg = 1'b1;
               s_d.winCnt = 6'h00;
               s_d.winErr = 6'h00;
            end
         end else begin
            // Once aligned the detector runs from its own prediction.
            s_d.shreg = {s_q.shreg[30:0], pred};
            s_d.winCnt = (s_q.winCnt == WIN - 6'h01) ? 6'h00 : s_q.winCnt + 6'h01;
            s_d.winErr = (s_q.winCnt == WIN - 6'h01) ? 6'h00 : errSum;
            case (s_q.st)
               DET_SYNC: begin
                  if (s_q.winCnt == WIN - 6'h01 && errSum >= LIM) begin
                     s_d.sync = 1'b0;
                     s_d.syncChg = 1'b1;
                     s_d.runCnt = 6'h00;
                     s_d.st = autoResync ? DET_SEARCH : DET_HOLD;
                  end
               end
               default: begin
                  if (!err && s_q.runCnt == WIN - 6'h01) begin
                     s_d.st = DET_SYNC;
                     s_d.sync = 1'b1;
                     s_d.syncChg = 1'b1;
                  end
               end
            endcase
         end
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end

   assign syncState = s_q.sync;
   assign syncChange = s_q.syncChg;
   assign bitError = s_q.bitErr;
   assign bitSeen = s_q.bitSeen;
   assign rxHist = s_q.rxHist;

endmodule

// ==== pattern_gen_detect.sv ====
// The implementer's own choice: the strobed register port.
`include "pattern_gen_detect_defs.svh"

// Contract
// - view select picks pattern, errors or bits
// - zero suppression forces one after 14 zeros
// - type select chooses repetitive or pseudo-random
// - transmit invert flips every generated bit
// - receive invert flips data before detection
// - 48 error-free bits declare sync
// - auto resync searches after 10 errors/48
// - without auto, only manual edge restarts search
// - manual resync acts on rising edge only
// - sync clears on 10 errors in window
// - sync change flag set, cleared by read
// - bit error flag only while synchronized
// - transfer flag set on holding update
// - transfer from result write, global, auto
// - three enables gate interrupt sources
// - overrun when transfer flag still pending
// - pattern length is field plus one
// - feedback tap is field plus one
module pattern_gen_detect import pattern_gen_detect_pkg::*; #(
   parameter int WIN_BITS = `SYNC_WINDOW_BITS,
   parameter int ERR_LIMIT = `LOSS_ERR_LIMIT,
   parameter int ZERO_RUN = `ZERO_RUN_LIMIT
) (
   // Clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // Register port
   input wire logic [7:0] regAddr,
   input wire logic [7:0] regWrData,
   input wire logic regWr,
   input wire logic regRd,
   output logic [7:0] regRdData,
   // Holding update requests from the framer
   input wire logic globalUpdate,
   input wire logic auto_holding_update,
   // Transmit stream
   input wire logic txBitEn,
   output logic txData,
   // Receive stream
   input wire logic rxBitEn,
   input wire logic rxData,
   // Interrupt request
   output logic intReq
);

   topState_t s_q, s_d;

   logic syncState;
   logic syncChange;
   logic bitError;
   logic bitSeen;
   logic [31:0] rxHist;

   logic wrCtrl;
   logic wrIrq;
   logic wrLen;
   logic wrTap;
   logic wrIns1;
   logic wrIns2;
   logic wrIns3;
   logic wrIns4;
   logic wrRes;
   logic rdIrq;
   logic xferNow;
   logic [31:0] viewWord;
   logic [1:0] viewSel;

   pattern_generator #(
      .ZERO_RUN(ZERO_RUN)
   ) u_gen (
      .clk(clk),
      .rst_n(rst_n),
      .patType(s_q.ctrl[`CTRL_PTYPE]),
      .zeroSup(s_q.ctrl[`CTRL_ZSUP]),
      .txInvert(s_q.ctrl[`CTRL_TXINV]),
      .lenField(s_q.lenField),
      .tapField(s_q.tapField),
      .load(s_q.loadPulse),
      .loadData(s_q.insData),
      .bitEn(txBitEn),
      .txData(txData)
   );

   pattern_detector #(
      .WIN_BITS(WIN_BITS),
      .ERR_LIMIT(ERR_LIMIT)
   ) u_det (
      .clk(clk),
      .rst_n(rst_n),
      .patType(s_q.ctrl[`CTRL_PTYPE]),
      .rxInvert(s_q.ctrl[`CTRL_RXINV]),
      .autoResync(s_q.ctrl[`CTRL_AUTO]),
      .manualResync(s_q.manPulse),
      .lenField(s_q.lenField),
      .tapField(s_q.tapField),
      .bitEn(rxBitEn),
      .rxData(rxData),
      .syncState(syncState),
      .syncChange(syncChange),
      .bitError(bitError),
      .bitSeen(bitSeen),
      .rxHist(rxHist)
   );

   // Address decode of write and read strobes.
   always_comb begin
      wrCtrl = 1'b0;
      wrIrq = 1'b0;
      wrLen = 1'b0;
      wrTap = 1'b0;
      wrIns1 = 1'b0;
      wrIns2 = 1'b0;
      wrIns3 = 1'b0;
      wrIns4 = 1'b0;
      wrRes = 1'b0;
      if (regAddr == `PGD_OFF_CTRL) begin
         wrCtrl = regWr;
      end else if (regAddr == `PGD_OFF_IRQ) begin
         wrIrq = regWr;
      end else if (regAddr == `PGD_OFF_LEN) begin
         wrLen = regWr;
      end else if (regAddr == `PGD_OFF_TAP) begin
         wrTap = regWr;
      end else if (regAddr == `PGD_OFF_INS1) begin
         wrIns1 = regWr;
      end else if (regAddr == `PGD_OFF_INS2) begin
         wrIns2 = regWr;
      end else if (regAddr == `PGD_OFF_INS3) begin
         wrIns3 = regWr;
      end else if (regAddr == `PGD_OFF_INS4) begin
         wrIns4 = regWr;
      end else if (regAddr >= `PGD_OFF_RES1 && regAddr <= `PGD_OFF_RES4) begin
         wrRes = regWr;
      end
      rdIrq = regRd && (regAddr == `PGD_OFF_IRQ);
      xferNow = wrRes || globalUpdate || auto_holding_update;
   end

   // Result view multiplexer.
   always_comb begin
      viewSel = s_q.ctrl[`CTRL_VIEW_HI:`CTRL_VIEW_LO];
      if (viewSel == `VIEW_ERR) begin
         viewWord = s_q.errHold;
      end else if (viewSel == `VIEW_BIT) begin
         viewWord = s_q.bitHold;
      end else begin
         viewWord = s_q.patHold;
      end
   end

   always_comb begin
      s_d = s_q;
      s_d.loadPulse = 1'b0;
      s_d.manPulse = 1'b0;

      // Register writes.
      if (wrCtrl) begin
         s_d.ctrl = regWrData;
         s_d.manPulse = regWrData[`CTRL_MAN] && !s_q.ctrl[`CTRL_MAN];
      end
      if (wrIrq) begin
         s_d.irqEn = regWrData[`IRQ_SYNC_EN:`IRQ_XFER_EN];
      end
      if (wrLen) begin
         s_d.lenField = regWrData[4:0];
      end
      if (wrTap) begin
         s_d.tapField = regWrData[4:0];
      end
      if (wrIns1) begin
         s_d.insData[7:0] = regWrData;
      end
      if (wrIns2) begin
         s_d.insData[15:8] = regWrData;
      end
      if (wrIns3) begin
         s_d.insData[23:16] = regWrData;
      end
      if (wrIns4) begin
         // The generator reloads only on the top byte, after the lower three.
         s_d.insData[31:24] = regWrData;
         s_d.loadPulse = 1'b1;
      end

      // Status read clears the flags; a new event in the same cycle wins.
      if (rdIrq) begin
         s_d.syncFlag = 1'b0;
         s_d.berrFlag = 1'b0;
         s_d.xferFlag = 1'b0;
         s_d.ovrFlag = 1'b0;
      end
      if (syncChange) begin
         s_d.syncFlag = 1'b1;
      end
      if (bitError) begin
         s_d.berrFlag = 1'b1;
      end

      // Live counters, restarted by each transfer.
      if (bitSeen && s_q.bitCnt != 32'hffffffff) begin
         s_d.bitCnt = s_q.bitCnt + 32'h00000001;
      end
      if (bitError && s_q.errCnt != 32'hffffffff) begin
         s_d.errCnt = s_q.errCnt + 32'h00000001;
      end
      if (xferNow) begin
         s_d.patHold = rxHist;
         s_d.bitHold = s_q.bitCnt;
         s_d.errHold = s_q.errCnt;
         s_d.bitCnt = {31'h00000000, bitSeen};
         s_d.errCnt = {31'h00000000, bitError};
         s_d.xferFlag = 1'b1;
         if (s_q.xferFlag && !rdIrq) begin
            s_d.ovrFlag = 1'b1;
         end
      end

      // Read data stands in the cycle after the strobe.
      s_d.rdData = 8'h00;
      if (regRd) begin
         if (regAddr == `PGD_OFF_CTRL) begin
            s_d.rdData = s_q.ctrl;
         end else if (regAddr == `PGD_OFF_IRQ) begin
            // The shown sync state waits for its change flag, so a read never sees one without the other.
            s_d.rdData = {s_q.irqEn, syncState ^ syncChange, s_q.syncFlag, s_q.berrFlag, s_q.xferFlag, s_q.ovrFlag};
         end else if (regAddr == `PGD_OFF_LEN) begin
            s_d.rdData = {3'h0, s_q.lenField};
         end else if (regAddr == `PGD_OFF_TAP) begin
            s_d.rdData = {3'h0, s_q.tapField};
         end else if (regAddr == `PGD_OFF_INS1) begin
            s_d.rdData = s_q.insData[7:0];
         end else if (regAddr == `PGD_OFF_INS2) begin
            s_d.rdData = s_q.insData[15:8];
         end else if (regAddr == `PGD_OFF_INS3) begin
            s_d.rdData = s_q.insData[23:16];
         end else if (regAddr == `PGD_OFF_INS4) begin
            s_d.rdData = s_q.insData[31:24];
         end else if (regAddr == `PGD_OFF_RES1) begin
            s_d.rdData = viewWord[7:0];
         end else if (regAddr == `PGD_OFF_RES1 + 8'h01) begin
            s_d.rdData = viewWord[15:8];
         end else if (regAddr == `PGD_OFF_RES1 + 8'h02) begin
            s_d.rdData = viewWord[23:16];
         end else if (regAddr == `PGD_OFF_RES4) begin
            s_d.rdData = viewWord[31:24];
         end
      end

      s_d.intReq = (s_d.syncFlag && s_d.irqEn[2]) || (s_d.berrFlag && s_d.irqEn[1]) ||
                   (s_d.xferFlag && s_d.irqEn[0]);
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         s_q <= '0;
         s_q.ctrl <= `CTRL_RESET;
      end else begin
         s_q <= s_d;
      end
   end

   assign regRdData = s_q.rdData;
   assign intReq = s_q.intReq;

endmodule

// ==== pattern_gen_detect_checker.sv ====
module pattern_gen_detect_checker (
   // Clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // Register port
   input wire logic [7:0] regAddr,
   input wire logic [7:0] regWrData,
   input wire logic regWr,
   input wire logic regRd,
   input wire logic [7:0] regRdData,
   // Update requests
   input wire logic globalUpdate,
   input wire logic auto_holding_update,
   // Streams and interrupt
   input wire logic txBitEn,
   input wire logic txData,
   input wire logic rxBitEn,
   input wire logic rxData,
   input wire logic intReq
);
   timeunit 1ns;
   timeprecision 1ns;
   typedef struct packed {
      logic ans;
      logic seen;
      logic sync;
   } watch_t;
   watch_t w_q;
   watch_t w_d;
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!rst_n);
   // Keeps the sync state shown by the previous status read.
   always_comb begin
      w_d = w_q;
      w_d.ans = regRd && regAddr == 8'h61;
      if (w_q.ans) begin
         w_d.seen = 1'b1;
         w_d.sync = regRdData[4];
      end
   end
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         w_q <= '0;
      end else begin
         w_q <= w_d;
      end
   end
   read_idle_zero_a:
      assert property (!$past(regRd) |-> regRdData == 8'h00) else $error("read data outside answer cycle");
   irq_follows_flags_a:
      assert property (w_q.ans |-> $past(intReq) == |(regRdData[7:5] & regRdData[3:1]))
      else $error("interrupt request disagrees with enabled flags");
   tx_moves_on_bit_a:
      assert property ($changed(txData) |-> $past(txBitEn)) else $error("transmit bit moved without enable");
   ctrl_readback_a:
      assert property ((regWr && regAddr == 8'h60) ##2 (regRd && regAddr == 8'h60) |=>
         regRdData == $past(regWrData, 3)) else $error("control read back wrong");
   irq_en_readback_a:
      assert property ((regWr && regAddr == 8'h61) ##2 (regRd && regAddr == 8'h61) |=>
         (regRdData & 8'he0) == ($past(regWrData, 3) & 8'he0)) else $error("enables read back wrong");
   len_readback_a:
      assert property ((regWr && regAddr == 8'h62) ##2 (regRd && regAddr == 8'h62) |=>
         regRdData == ($past(regWrData, 3) & 8'h1f)) else $error("length read back wrong");
   tap_readback_a:
      assert property ((regWr && regAddr == 8'h63) ##2 (regRd && regAddr == 8'h63) |=>
         regRdData == ($past(regWrData, 3) & 8'h1f)) else $error("tap read back wrong");
   sync_change_a:
      assert property (w_q.ans && w_q.seen && regRdData[4] != w_q.sync |-> regRdData[3])
      else $error("sync moved without change flag");
endmodule

// ==== pattern_gen_detect_defs.svh ====
`ifndef PATTERN_GEN_DETECT_DEFS_SVH
`define PATTERN_GEN_DETECT_DEFS_SVH

// Register offsets within one octant.
`define PGD_OFF_CTRL 8'h60
`define PGD_OFF_IRQ 8'h61
`define PGD_OFF_LEN 8'h62
`define PGD_OFF_TAP 8'h63
`define PGD_OFF_INS1 8'h68
`define PGD_OFF_INS2 8'h69
`define PGD_OFF_INS3 8'h6a
`define PGD_OFF_INS4 8'h6b
`define PGD_OFF_RES1 8'h6c
`define PGD_OFF_RES4 8'h6f

// Control register fields.
`define CTRL_VIEW_HI 7
`define CTRL_VIEW_LO 6
`define CTRL_ZSUP 5
`define CTRL_PTYPE 4
`define CTRL_TXINV 3
`define CTRL_RXINV 2
`define CTRL_AUTO 1
`define CTRL_MAN 0
`define CTRL_RESET 8'h02

// Interrupt enable and status fields.
`define IRQ_SYNC_EN 7
`define IRQ_BERR_EN 6
`define IRQ_XFER_EN 5
`define IRQ_SYNC_ST 4
`define IRQ_SYNC_FL 3
`define IRQ_BERR_FL 2
`define IRQ_XFER_FL 1
`define IRQ_OVR_FL 0

// Result view select codes.
`define VIEW_ERR 2'h2
`define VIEW_BIT 2'h3

// Timing counts in bits.
`define SYNC_WINDOW_BITS 48
`define LOSS_ERR_LIMIT 10
`define ZERO_RUN_LIMIT 14
`define PATTERN_BITS 32

`endif

// ==== pattern_gen_detect_pkg.sv ====
package pattern_gen_detect_pkg;

   typedef enum logic [1:0] {
      DET_SEARCH = 2'b00,
      DET_SYNC = 2'b01,
      DET_HOLD = 2'b10
   } detState_t;

   typedef struct packed {
      logic [31:0] shreg;
      logic [5:0] headCnt;
      logic [4:0] zeroRun;
      logic txBit;
   } genState_t;

   typedef struct packed {
      detState_t st;
      logic [31:0] shreg;
      logic [31:0] rxHist;
      logic [5:0] runCnt;
      logic [5:0] winCnt;
      logic [5:0] winErr;
      logic sync;
      logic syncChg;
      logic bitErr;
      logic bitSeen;
   } detCore_t;

   typedef struct packed {
      logic [7:0] ctrl;
      logic [2:0] irqEn;
      logic [4:0] lenField;
      logic [4:0] tapField;
      logic [31:0] insData;
      logic loadPulse;
      logic manPulse;
      logic syncFlag;
      logic berrFlag;
      logic xferFlag;
      logic ovrFlag;
      logic [31:0] errCnt;
      logic [31:0] bitCnt;
      logic [31:0] patHold;
      logic [31:0] errHold;
      logic [31:0] bitHold;
      logic [7:0] rdData;
      logic intReq;
   } topState_t;

endpackage

// ==== pattern_generator.sv ====
`include "pattern_gen_detect_defs.svh"

module pattern_generator import pattern_gen_detect_pkg::*; #(
   parameter int ZERO_RUN = `ZERO_RUN_LIMIT
) (
   // Clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // Configuration
   input wire logic patType,
   input wire logic zeroSup,
   input wire logic txInvert,
   input wire logic [4:0] lenField,
   input wire logic [4:0] tapField,
   input wire logic load,
   input wire logic [31:0] loadData,
   // Bit stream
   input wire logic bitEn,
   output logic txData
);

   generate
      if (ZERO_RUN < 1 || ZERO_RUN > 30) begin : g_bad
         $error("ZERO_RUN out of range");
      end
   endgenerate

   localparam logic [4:0] RUN_MAX = 5'(ZERO_RUN);

   genState_t s_q, s_d;
   logic rawBit;
   logic outBit;

   always_comb begin
      s_d = s_q;
      rawBit = (s_q.headCnt != 6'h00) ? s_q.shreg[31] : s_q.shreg[lenField];
      outBit = rawBit;
      if (load) begin
         s_d.shreg = loadData;
         s_d.headCnt = patType ? 6'(`PATTERN_BITS) : 6'h00;
         s_d.zeroRun = 5'h00;
      end else if (bitEn) begin
         if (patType) begin
            if (s_q.headCnt != 6'h00) begin
               s_d.shreg = {s_q.shreg[30:0], s_q.shreg[31]};
               s_d.headCnt = s_q.headCnt - 6'h01;
            end else begin
               s_d.shreg = {s_q.shreg[30:0], s_q.shreg[lenField]};
            end
         end else begin
            s_d.shreg = {s_q.shreg[30:0], s_q.shreg[lenField] ^ s_q.shreg[tapField]};
         end
         if (zeroSup && s_q.zeroRun >= RUN_MAX) begin
            outBit = 1'b1;
         end
         s_d.zeroRun = outBit ? 5'h00 : ((s_q.zeroRun >= RUN_MAX) ? s_q.zeroRun : s_q.zeroRun + 5'h01);
         s_d.txBit = outBit ^ txInvert;
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end

   assign txData = s_q.txBit;

endmodule

// ==== testbench.sv ====
module testbench;
   timeunit 1ns;
   timeprecision 1ns;
   logic clk, rst_n, regWr, regRd, globalUpdate, auto_holding_update, txBitEn, txData, rxBitEn, rxData, intReq;
   logic run, slow, injectErr, chkOn;
   logic txEnD = 1'b0;
   logic [7:0] regAddr, regWrData, regRdData;
   logic [2:0] chkMode;
   logic [15:0] txHist = 16'h0000;
   logic [31:0] rxExp = 32'h00000000;
   int cyc, failCount, nCompared;
   pattern_gen_detect i_pattern_gen_detect (.clk, .rst_n, .regAddr, .regWrData, .regWr, .regRd, .regRdData,
      .globalUpdate, .auto_holding_update, .txBitEn, .txData, .rxBitEn, .rxData, .intReq);
   framer_model i_framer_model (.clk, .rst_n, .run, .slow, .injectErr, .txData, .txBitEn, .rxBitEn, .rxData);
   always #5 clk = ~clk;
   task automatic report_and_stop();
      $display("compared %0d, mismatches %0d", nCompared, failCount);
      if (failCount == 0 && nCompared > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask
   task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
      nCompared++;
      if (seen !== exp) begin
         failCount++;
         $display("ERROR at %0t: seen %h, expected %h", $time, seen, exp);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk);
      regWr <= 1'b1;
      regAddr <= a;
      regWrData <= d;
      @(posedge clk);
      regWr <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, input logic [7:0] exp);
      @(posedge clk);
      regRd <= 1'b1;
      regAddr <= a;
      @(posedge clk);
      regRd <= 1'b0;
      #1 chk(regRdData, exp);
   endtask
   task automatic rd4(input logic [31:0] exp);
      for (int i = 0; i < 4; i++) rd(8'h6c + 8'(i), exp[8*i +: 8]);
   endtask
   task automatic load(input logic [31:0] pi);
      for (int i = 0; i < 4; i++) wr(8'h68 + 8'(i), pi[8*i +: 8]);
   endtask
   task automatic upd(input logic g);
      @(posedge clk);
      globalUpdate <= g;
      auto_holding_update <= !g;
      @(posedge clk);
      globalUpdate <= 1'b0;
      auto_holding_update <= 1'b0;
   endtask
   task automatic bits(input int n, input int e);
      @(posedge clk);
      for (int i = 0; i < n; i++) begin
         run <= 1'b1;
         injectErr <= (i < e);
         @(posedge clk iff rxBitEn);
      end
      run <= 1'b0;
      injectErr <= 1'b0;
   endtask
   task automatic pat(input logic [2:0] m);
      bits(40, 0);
      chkMode <= m;
      chkOn <= 1'b1;
      bits(40, 0);
      chkOn <= 1'b0;
      $display("pattern test %0d done", m);
   endtask
   // While chkOn is set, each new transmit bit is checked against the bits sent before it.
   always @(posedge clk) begin
      cyc++;
      if (cyc == 30000) begin
         failCount++;
         report_and_stop();
      end
      txEnD <= txBitEn;
      if (txEnD) begin
         if (chkOn) begin
            case (chkMode)
               3'h1: chk({7'h0, txData}, {7'h0, txHist[6] ^ txHist[5]});
               3'h2: chk({7'h0, txData}, {7'h0, ~(txHist[6] ^ txHist[5])});
               3'h3: chk({7'h0, txData}, {7'h0, txHist[3]});
               3'h4: chk({7'h0, txData}, {7'h0, txHist[13:0] == 14'h0});
               default: ;
            endcase
         end
         txHist <= {txHist[14:0], txData};
      end
      if (rxBitEn) rxExp <= {rxExp[30:0], rxData};
   end
   initial begin
      clk = 1'b0;
      rst_n = 1'b0;
      {regWr, regRd, globalUpdate, auto_holding_update, run, slow, injectErr, chkOn} = '0;
      {regAddr, regWrData, chkMode} = '0;
      repeat (6) @(posedge clk);
      rst_n <= 1'b1;
      rd(8'h60, 8'h02);
      rd(8'h61, 8'h00);
      rd(8'h64, 8'h00);
      wr(8'h62, 8'hff);
      rd(8'h62, 8'h1f);
      wr(8'h63, 8'he5);
      rd(8'h63, 8'h05);
      wr(8'h61, 8'he0);
      rd(8'h61, 8'he0);
      wr(8'h60, 8'hfe);
      rd(8'h60, 8'hfe);
      wr(8'h61, 8'h00);
      $display("register test done");
      wr(8'h60, 8'h02);
      wr(8'h62, 8'h06);
      wr(8'h63, 8'h05);
      load(32'hffffffff);
      pat(3'h1);
      rd(8'h61, 8'h18);
      rd(8'h61, 8'h10);
      wr(8'h6c, 8'h00);
      rd(8'h61, 8'h12);
      bits(40, 2);
      upd(1'b1);
      rd(8'h61, 8'h16);
      wr(8'h60, 8'hc2);
      rd4(32'd40);
      wr(8'h60, 8'h82);
      rd4(32'd2);
      wr(8'h60, 8'h42);
      rd4(rxExp);
      upd(1'b0);
      upd(1'b0);
      rd(8'h61, 8'h13);
      upd(1'b1);
      repeat (3) @(posedge clk);
      #1 chk({7'h0, intReq}, 8'h00);
      wr(8'h61, 8'h20);
      repeat (2) @(posedge clk);
      #1 chk({7'h0, intReq}, 8'h01);
      rd(8'h61, 8'h32);
      repeat (2) @(posedge clk);
      #1 chk({7'h0, intReq}, 8'h00);
      wr(8'h61, 8'hc0);
      $display("transfer test done");
      bits(20, 20);
      bits(47, 0);
      #1 chk({7'h0, intReq}, 8'h01);
      rd(8'h61, 8'hcc);
      wr(8'h61, 8'h00);
      bits(50, 0);
      rd(8'h61, 8'h18);
      wr(8'h60, 8'h00);
      wr(8'h60, 8'h01);
      repeat (4) @(posedge clk);
      rd(8'h61, 8'h08);
      bits(60, 0);
      rd(8'h61, 8'h18);
      wr(8'h60, 8'h01);
      repeat (4) @(posedge clk);
      rd(8'h61, 8'h10);
      $display("sync test done");
      wr(8'h60, 8'h0a);
      pat(3'h2);
      rd(8'h61, 8'h0c);
      bits(60, 0);
      rd(8'h61, 8'h00);
      wr(8'h60, 8'h0e);
      bits(60, 0);
      rd(8'h61, 8'h18);
      wr(8'h60, 8'h12);
      wr(8'h62, 8'h03);
      load(32'h0000000c);
      pat(3'h3);
      slow <= 1'b1;
      wr(8'h60, 8'h32);
      wr(8'h62, 8'h1f);
      load(32'h00000000);
      pat(3'h4);
      report_and_stop();
   end
endmodule
bind pattern_gen_detect pattern_gen_detect_checker i_pattern_gen_detect_checker (.clk, .rst_n, .regAddr,
   .regWrData, .regWr, .regRd, .regRdData, .globalUpdate, .auto_holding_update, .txBitEn, .txData, .rxBitEn, .rxData,
   .intReq);
